// [hdl/agcl_pkg.sv]
// register map and field layout of the gain loop control bank
package agcl_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h14;
  localparam logic [7:0] IDX_CNT_LO = 8'h15;
  localparam logic [7:0] IDX_CNT_HI = 8'h16;
  localparam logic [7:0] IDX_IC_A = 8'h17;
  localparam logic [7:0] IDX_IC_B = 8'h18;
  localparam logic [7:0] IDX_RB_A = 8'h19;
  localparam logic [7:0] IDX_RB_B = 8'h1a;
  // loop_control fields
  localparam int BIT_ALWAYS_ON = 1;
  localparam int BIT_RELOAD = 2;
  localparam int BIT_HOLD = 3;
  localparam int SHIFT_LSB = 4;
  localparam int SHIFT_MSB = 5;
  localparam logic [7:0] RST_CTRL = 8'h02;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam int IC_W = 8;
endpackage : agcl_pkg

// [hdl/agcl_regs.sv]
// gain loop control registers, window counter and channel integrators
//
// Design decision made here: the AHB-Lite register port.
module agcl_regs #(
  parameter int INT_W = 16,
  parameter int ERR_W = 12
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic loop_enable_pin,
  input wire logic signed [ERR_W-1:0] err_a,
  input wire logic signed [ERR_W-1:0] err_b,
  output logic [INT_W-1:0] gain_a,
  output logic [INT_W-1:0] gain_b,
  output logic loop_active
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [INT_W-1:0] ic_word(
    input logic [agcl_pkg::IC_W-1:0] ic
  );
    ic_word = {ic, {(INT_W-agcl_pkg::IC_W){1'b0}}};
  endfunction : ic_word

  function automatic logic [INT_W-1:0] step(
    input logic [INT_W-1:0] cur,
    input logic signed [ERR_W-1:0] e,
    input logic [1:0] sh
  );
    logic signed [ERR_W-1:0] d;
    logic signed [INT_W+1:0] sum;
    // arithmetic shift keeps the sign of the error; the sum saturates
    // at both ends so a large error cannot wrap the gain around
    d = e >>> sh;
    sum = $signed({2'b00, cur}) + {{(INT_W+2-ERR_W){d[ERR_W-1]}}, d};
    if (sum[INT_W+1])
      step = '0;
    else if (sum[INT_W])
      step = '1;
    else
      step = sum[INT_W-1:0];
  endfunction : step

  // ----------------------------------------------------------------
  // channel integrator state
  // ----------------------------------------------------------------
  // declared ahead of the bus logic, whose readback mux samples it
  logic [INT_W-1:0] integ_r [2];
  logic [INT_W-1:0] integ_nxt [2];

  // ----------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_idx_r, wr_idx_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [15:0] count_r, count_nxt;
  logic [7:0] ic_a_r, ic_a_nxt;
  logic [7:0] ic_b_r, ic_b_nxt;
  logic accept;
  logic [7:0] a_idx;

  assign accept = hsel && htrans[1] && hready;
  assign a_idx = haddr[9:2];
  // zero wait states: no transfer is ever stretched
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = {24'h00_0000, rdata_r};

  // read data is captured at the address phase edge, so a readback
  // byte is one snapshot of the integrator
  always_comb
  begin
    wr_pend_nxt = accept && hwrite;
    wr_idx_nxt = accept ? a_idx : wr_idx_r;
    rdata_nxt = rdata_r;
    if (accept && !hwrite)
    begin
      unique case (a_idx)
        agcl_pkg::IDX_CTRL: rdata_nxt = ctrl_r;
        agcl_pkg::IDX_CNT_LO: rdata_nxt = count_r[7:0];
        agcl_pkg::IDX_CNT_HI: rdata_nxt = count_r[15:8];
        agcl_pkg::IDX_IC_A: rdata_nxt = ic_a_r;
        agcl_pkg::IDX_IC_B: rdata_nxt = ic_b_r;
        agcl_pkg::IDX_RB_A: rdata_nxt = integ_r[0][INT_W-1 -: 8];
        agcl_pkg::IDX_RB_B: rdata_nxt = integ_r[1][INT_W-1 -: 8];
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      rdata_r <= 8'h00;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      wr_idx_r <= wr_idx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // a write lands at the edge that closes its data phase; read-only
  // and unmapped indices are dropped
  always_comb
  begin
    ctrl_nxt = ctrl_r;
    count_nxt = count_r;
    ic_a_nxt = ic_a_r;
    ic_b_nxt = ic_b_r;
    if (wr_pend_r)
    begin
      unique case (wr_idx_r)
        agcl_pkg::IDX_CTRL: ctrl_nxt = {2'b00, hwdata[5:1], 1'b0};
        agcl_pkg::IDX_CNT_LO: count_nxt[7:0] = hwdata[7:0];
        agcl_pkg::IDX_CNT_HI: count_nxt[15:8] = hwdata[7:0];
        agcl_pkg::IDX_IC_A: ic_a_nxt = hwdata[7:0];
        agcl_pkg::IDX_IC_B: ic_b_nxt = hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_r <= agcl_pkg::RST_CTRL;
      count_r <= agcl_pkg::RST_COUNT;
      ic_a_r <= agcl_pkg::RST_BYTE;
      ic_b_r <= agcl_pkg::RST_BYTE;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      count_r <= count_nxt;
      ic_a_r <= ic_a_nxt;
      ic_b_r <= ic_b_nxt;
    end
  end

  // ----------------------------------------------------------------
  // enable pin synchroniser
  // ----------------------------------------------------------------
  logic [2:0] sync_r, sync_nxt;
  logic en_r, en_nxt;
  logic en_rise;

  // a level counts only once the second and third stages agree; the
  // settled level rests low after reset like the idle pin, so reset
  // never fakes a rise
  always_comb
  begin
    sync_nxt = {sync_r[1:0], loop_enable_pin};
    en_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : en_r;
  end

  assign en_rise = en_nxt && !en_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync_r <= 3'b000;
      en_r <= 1'b0;
    end
    else
    begin
      sync_r <= sync_nxt;
      en_r <= en_nxt;
    end
  end

  // ----------------------------------------------------------------
  // active window
  // ----------------------------------------------------------------
  logic [15:0] win_r, win_nxt;
  logic active_r, active_nxt;
  logic activate;

  always_comb
  begin
    win_nxt = win_r;
    if (ctrl_r[agcl_pkg::BIT_ALWAYS_ON])
    begin
      // the counter rests at zero, so clearing the bit ends the run
      win_nxt = 16'h0000;
      active_nxt = 1'b1;
    end
    else
    begin
      // a rise inside a running window reloads the count without a
      // fresh activation; a count of zero never opens a window
      if (en_rise)
        win_nxt = count_r;
      else if (win_r != 16'h0000)
        win_nxt = win_r - 16'h0001;
      active_nxt = (win_nxt != 16'h0000);
    end
  end

  assign activate = active_nxt && !active_r;
  assign loop_active = active_r;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      win_r <= 16'h0000;
      active_r <= 1'b0;
    end
    else
    begin
      win_r <= win_nxt;
      active_r <= active_nxt;
    end
  end

  // ----------------------------------------------------------------
  // channel integrators
  // ----------------------------------------------------------------
  logic signed [ERR_W-1:0] err [2];
  logic [INT_W-1:0] ic [2];
  logic [1:0] shift;
  logic reload;

  assign err[0] = err_a;
  assign err[1] = err_b;
  assign ic[0] = ic_word(ic_a_r);
  assign ic[1] = ic_word(ic_b_r);
  assign shift = ctrl_r[agcl_pkg::SHIFT_MSB:agcl_pkg::SHIFT_LSB];
  assign reload = activate && ctrl_r[agcl_pkg::BIT_RELOAD];

  always_comb
  begin
    // hold outranks both the activation reload and the loop step
    for (int c = 0; c < 2; c++)
    begin
      if (ctrl_r[agcl_pkg::BIT_HOLD])
        integ_nxt[c] = ic[c];
      else if (reload)
        integ_nxt[c] = ic[c];
      else if (active_r)
        integ_nxt[c] = step(integ_r[c], err[c], shift);
      else
        integ_nxt[c] = integ_r[c];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      integ_r[0] <= '0;
      integ_r[1] <= '0;
    end
    else
    begin
      integ_r[0] <= integ_nxt[0];
      integ_r[1] <= integ_nxt[1];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign gain_a = integ_r[0];
  assign gain_b = integ_r[1];

endmodule : agcl_regs

// [verification/agcl_regs_sva.sv]
// assertion checker for the gain loop control registers
module agcl_regs_sva (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic loop_enable_pin,
  input wire logic signed [11:0] err_a,
  input wire logic [15:0] gain_a,
  input wire logic [15:0] gain_b,
  input wire logic loop_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c_r, lo_r, hi_r, a_r, b_r, ix_r;
  logic we_r, win_r;
  logic [15:0] run_r;
  // shadow of the writable bytes and the length of the current active run
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      {we_r, win_r, run_r, ix_r} <= '0;
      {c_r, lo_r, hi_r, a_r, b_r} <= {8'h02, 32'h0000_0000};
    end
    else
    begin
      we_r <= hsel && htrans[1] && hready && hwrite;
      ix_r <= haddr[9:2];
      if (we_r)
        case (ix_r)
          8'h14: c_r <= hwdata[7:0];
          8'h15: lo_r <= hwdata[7:0];
          8'h16: hi_r <= hwdata[7:0];
          8'h17: a_r <= hwdata[7:0];
          8'h18: b_r <= hwdata[7:0];
          default: ;
        endcase
      run_r <= loop_active ? run_r + 16'h0001 : 16'h0000;
      win_r <= loop_active && (run_r == 16'h0000 ? !c_r[1] : win_r);
    end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rd(logic [7:0] i);
    hsel && htrans[1] && hready && !hwrite && haddr[9:2] == i;
  endsequence
  property p_rb_a;
    s_rd(8'h19) |=> hrdata == {24'h00_0000, $past(gain_a[15:8])};
  endproperty
  a_rb_a: assert property (p_rb_a) else $error("readback a");
  property p_rb_b;
    s_rd(8'h1a) |=> hrdata == {24'h00_0000, $past(gain_b[15:8])};
  endproperty
  a_rb_b: assert property (p_rb_b) else $error("readback b");
  property p_aon;
    c_r[1] && $past(c_r[1]) |=> loop_active;
  endproperty
  a_aon: assert property (p_aon) else $error("loop not on");
  property p_hold;
    c_r[3] |=> gain_a == {$past(a_r), 8'h00} && gain_b == {$past(b_r), 8'h00};
  endproperty
  a_hold: assert property (p_hold) else $error("hold lost");
  property p_load;
    $rose(loop_active) && c_r[2] |-> gain_a == {a_r, 8'h00}
      && gain_b == {b_r, 8'h00};
  endproperty
  a_load: assert property (p_load) else $error("no reload");
  property p_win;
    $fell(loop_active) && win_r |-> run_r == {hi_r, lo_r};
  endproperty
  a_win: assert property (p_win) else $error("window length");
  property p_act;
    $rose(loop_enable_pin) && !c_r[1] && {hi_r, lo_r} != 16'h0000
      |-> ##[1:6] loop_active;
  endproperty
  a_act: assert property (p_act) else $error("no activation");
  property p_shift;
    loop_active && !c_r[3] && gain_a > 16'h0800 && gain_a < 16'hf000
      |=> gain_a == 16'($past(gain_a) + 16'($past(err_a) >>> $past(c_r[5:4])));
  endproperty
  a_shift: assert property (p_shift) else $error("loop step");
endmodule : agcl_regs_sva

bind agcl_regs agcl_regs_sva agcl_regs_sva_i (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata),
  .loop_enable_pin(loop_enable_pin),
  .err_a(err_a),
  .gain_a(gain_a),
  .gain_b(gain_b),
  .loop_active(loop_active)
);

// [verification/tb_agcl_regs.sv]
// self-checking bench for the gain loop control registers
`define CHK(a, e) \
  begin checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h want %h", $time, a, e); end end
module tb_agcl_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, loop_enable_pin = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic signed [11:0] err_a = 0, err_b = 0;
  logic [15:0] gain_a, gain_b, g;
  logic hreadyout, hresp, loop_active;
  int error_cnt = 0, checks = 0, cyc = 0, n;
  agcl_regs agcl_regs_i (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(3'b010),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .loop_enable_pin(loop_enable_pin),
    .err_a(err_a),
    .err_b(err_b),
    .gain_a(gain_a),
    .gain_b(gain_b),
    .loop_active(loop_active)
  );
  always #4 hclk = ~hclk;
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic finish_test();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // one single-word transfer, read data left in rd
  task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h00_0000, i, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    bus(1, 8'h19, 8'hff);
    for (int i = 0; i < 8; i++)
    begin
      bus(0, i == 7 ? 8'h20 : 8'(8'h14 + i), 8'h00);
      `CHK(rd, (i ? 32'h0000_0000 : 32'h0000_0002))
      `CHK({hresp, hreadyout}, 2'b01)
    end
    err_a <= 12'sd64;
    err_b <= -12'sd64;
    bus(1, 8'h17, 8'h5a);
    bus(1, 8'h18, 8'ha5);
    bus(1, 8'h14, 8'h0a);
    repeat (3) @(posedge hclk);
    bus(0, 8'h19, 8'h00);
    `CHK(rd, 32'h0000_005a)
    bus(0, 8'h1a, 8'h00);
    `CHK(rd, 32'h0000_00a5)
    @(negedge hclk);
    `CHK(gain_a, 16'h5a00)
    `CHK(gain_b, 16'ha500)
    @(posedge hclk);
    for (int s = 0; s < 4; s++)
    begin
      bus(1, 8'h14, 8'((s << 4) | 2));
      @(negedge hclk);
      g = gain_a;
      @(negedge hclk);
      `CHK(gain_a, 16'(g + 16'(err_a >>> s)))
      @(posedge hclk);
    end
    err_a <= 0;
    err_b <= 0;
    bus(1, 8'h15, 8'h05);
    bus(1, 8'h16, 8'h01);
    for (int k = 0; k < 2; k++)
    begin
      bus(1, 8'h14, k ? 8'h00 : 8'h04);
      bus(1, 8'h17, k ? 8'h33 : 8'h5a);
      loop_enable_pin <= 1;
      do @(negedge hclk); while (loop_active !== 1'b1);
      `CHK(gain_a, 16'h5a00)
      n = 0;
      do
      begin
        n++;
        @(negedge hclk);
      end
      while (loop_active === 1'b1);
      `CHK(n, 261)
      @(posedge hclk);
      loop_enable_pin <= 0;
      repeat (5) @(posedge hclk);
    end
    finish_test();
  end
endmodule : tb_agcl_regs
